// *** rtl/dtcs_pkg.sv ***
package dtcs_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 100_000_000; // System clock rate
   localparam int unsigned T_INTEG_MS = 60; // Integration per channel, ms
   localparam int unsigned T_CONV_MS = 125; // Whole two-channel conversion, ms
   localparam int unsigned T_RATE_MS = 250; // Free-running idle gap, ms
   localparam int unsigned INTEG_CYC = CLK_HZ / 1000 * T_INTEG_MS;
   // Settle share: what is left of the conversion time, split over both channels
   localparam int unsigned SETTLE_CYC = (CLK_HZ / 1000 * T_CONV_MS - 2 * INTEG_CYC) / 2;
   localparam int unsigned RATE_CYC = CLK_HZ / 1000 * T_RATE_MS;
   localparam int unsigned CNT_W = 26; // Holds the longest count above

   // ****************************************
   // Pin synchroniser layout
   // ****************************************
   localparam int unsigned PIN_W = 5;
   localparam int unsigned PIN_HW_STANDBY_PIN = 0; // Hardware standby pin, low = standby
   localparam int unsigned PIN_ADDR_LO = 1;
   localparam int unsigned PIN_ADDR_HI = 2;
   localparam int unsigned PIN_SCL = 3;
   localparam int unsigned PIN_SDA = 4;
   localparam logic [2:0] ADDR_FILL = 3'h4; // Cycles until sync pipe is primed

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [7:0] TEMP_RST = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [6:0] {
      S_IDLE  = 7'h01,
      S_SETL  = 7'h02,
      S_INTL  = 7'h04,
      S_SETR  = 7'h08,
      S_INTR  = 7'h10,
      S_LATCH = 7'h20,
      S_CMP   = 7'h40
   } dtcs_state_t;

endpackage : dtcs_pkg

// *** rtl/dtcs_sync_if.sv ***
// ****************************************
// Raw pins in, filtered levels out
// ****************************************
interface dtcs_sync_if #(parameter int W = 5);
   logic [W-1:0] raw; // Asynchronous pin levels
   logic [W-1:0] clean; // Filtered levels on the system clock
   modport sync_side (input raw, output clean);
   modport user_side (output raw, input clean);
endinterface : dtcs_sync_if

// *** rtl/dtcs_sync.sv ***
module dtcs_sync #(
   parameter int W = 5
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pins and filtered levels
   dtcs_sync_if.sync_side port
);

   // ****************************************
   // Three-stage synchroniser per pin
   // ****************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q; // Metastable stage, read only by s2
         logic s2_q;
         logic s3_q;
         logic clean_q; // Accepted level
         // A change counts once the second and third stage agree
         always_ff @(posedge clock) begin
            if (rst) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               clean_q <= 1'b0;
            end else begin
               s1_q <= port.raw[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  clean_q <= s3_q;
               end
            end
         end
         assign port.clean[i] = clean_q;
      end
   endgenerate

endmodule : dtcs_sync

// *** rtl/dtcs_sequencer.sv ***
// Operation
// - Standby pin low pauses, high runs
// - Standby keeps results and thresholds unchanged
// - Address pins sampled once after power-up
// - Open-drain alert output signals the host
// - Data line open-drain driven, also received
// - Each measurement is an 8-bit value
// - Results land in two registers, then compared
// - Each channel integrates about sixty milliseconds
// - Every started conversion covers both channels
// - Unused channel still measured regardless
// - Start command or free-run start converts both
// - Busy flag while conversion truly runs
// - Reads during conversion show previous results
// - Standby by pin low or halt bit
// - One-shot blocked by pin, allowed by halt
// - Standby mid-conversion aborts, discards new data
// - Full conversion takes nominally 125 ms
module dtcs_sequencer #(
   parameter int unsigned INTEG_CYC = dtcs_pkg::INTEG_CYC,
   parameter int unsigned SETTLE_CYC = dtcs_pkg::SETTLE_CYC,
   parameter int unsigned RATE_CYC = dtcs_pkg::RATE_CYC
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Device pins
   input wire logic hw_standby_pin,
   input wire logic addr_select_lo_pin,
   input wire logic addr_select_hi_pin,
   input wire logic smb_clk_pin,
   input wire logic smb_data_in,
   output logic smb_data_out,
   output logic smb_data_oe,
   output logic alert_out,
   output logic alert_oe,
   // Serial engine side
   input wire logic tx_pull_low,
   output logic smb_clk_rise,
   output logic smb_clk_fall,
   output logic smb_data_level,
   output logic [1:0] bus_addr_sel,
   output logic addr_valid,
   // Commands and configuration
   input wire logic one_shot_cmd,
   input wire logic sw_halt,
   input wire logic alarm_clear,
   input wire logic [7:0] lim_local_hi,
   input wire logic [7:0] lim_local_lo,
   input wire logic [7:0] lim_remote_hi,
   input wire logic [7:0] lim_remote_lo,
   // Analog front end
   output logic adc_integrate,
   output logic adc_channel_remote,
   input wire logic [7:0] adc_code,
   // Status
   output logic [7:0] temp_local,
   output logic [7:0] temp_remote,
   output logic busy,
   output logic standby_active,
   output logic [3:0] alarm_flags,
   output logic conv_done
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   dtcs_sync_if #(.W(dtcs_pkg::PIN_W)) pins_if ();
   assign pins_if.raw = {smb_data_in, smb_clk_pin, addr_select_hi_pin,
                         addr_select_lo_pin, hw_standby_pin};

   dtcs_sync #(.W(dtcs_pkg::PIN_W)) u_sync (
      .clock(clock),
      .rst(rst),
      .port(pins_if.sync_side)
   );

   // ****************************************
   // Declarations
   // ****************************************
   dtcs_pkg::dtcs_state_t state_q, state_d; // Sequencer state
   logic [dtcs_pkg::CNT_W-1:0] cnt_q; // Phase and rate timer
   logic [7:0] scratch_local_q; // Local result awaiting latch
   logic [7:0] scratch_remote_q; // Remote result awaiting latch
   logic [7:0] temp_local_q, temp_remote_q; // Visible results
   logic [3:0] flags_q; // Sticky alarms: lh, ll, rh, rl
   logic busy_q, standby_q, done_q;
   logic integ_q, chan_q;
   logic scl_prev_q, sw_halt_prev_q;
   logic rise_q, fall_q, sda_lvl_q, sda_oe_q, alert_oe_q;
   logic [2:0] fill_q; // Cycles since reset release
   logic [1:0] addr_q;
   logic addr_valid_q;

   // ****************************************
   // Decoding
   // ****************************************
   wire hw_hw_standby_pin = ~pins_if.clean[dtcs_pkg::PIN_HW_STANDBY_PIN]; // Pin low = standby
   wire scl_lvl = pins_if.clean[dtcs_pkg::PIN_SCL];
   wire halt_rise = sw_halt & ~sw_halt_prev_q;
   wire standby_now = hw_hw_standby_pin | sw_halt; // Either source pauses
   wire st_idle = (state_q == dtcs_pkg::S_IDLE);
   wire st_intl = (state_q == dtcs_pkg::S_INTL);
   wire st_intr = (state_q == dtcs_pkg::S_INTR);
   wire st_latch = (state_q == dtcs_pkg::S_LATCH);
   wire st_cmp = (state_q == dtcs_pkg::S_CMP);
   wire running = ~st_idle & ~st_latch & ~st_cmp;
   // Only a fresh halt request aborts, so a one-shot under halt can finish
   wire abort = running & (hw_hw_standby_pin | halt_rise);
   wire [dtcs_pkg::CNT_W-1:0] settle_last = dtcs_pkg::CNT_W'(SETTLE_CYC - 1);
   wire [dtcs_pkg::CNT_W-1:0] integ_last = dtcs_pkg::CNT_W'(INTEG_CYC - 1);
   wire [dtcs_pkg::CNT_W-1:0] rate_last = dtcs_pkg::CNT_W'(RATE_CYC - 1);
   wire is_settle = (state_q == dtcs_pkg::S_SETL) | (state_q == dtcs_pkg::S_SETR);
   wire phase_end = (is_settle & (cnt_q == settle_last)) |
                    ((st_intl | st_intr) & (cnt_q == integ_last));
   wire rate_done = st_idle & (cnt_q >= rate_last);
   // Hardware standby blocks every start; halt blocks only free-running
   wire start_req = st_idle & ~hw_hw_standby_pin &
                    (one_shot_cmd | (~sw_halt & rate_done));
   // Signed compare of fresh results against stored thresholds
   wire [3:0] hits = {$signed(temp_local_q) > $signed(lim_local_hi),
                      $signed(temp_local_q) < $signed(lim_local_lo),
                      $signed(temp_remote_q) > $signed(lim_remote_hi),
                      $signed(temp_remote_q) < $signed(lim_remote_lo)};
   // Set wins over a clear arriving in the same cycle
   wire [3:0] flags_d = (flags_q & ~{4{alarm_clear}}) | (st_cmp ? hits : 4'h0);

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         dtcs_pkg::S_IDLE: begin
            if (start_req) begin
               state_d = dtcs_pkg::S_SETL; // Always local then remote
            end
         end
         dtcs_pkg::S_SETL: begin
            if (phase_end) begin
               state_d = dtcs_pkg::S_INTL;
            end
         end
         dtcs_pkg::S_INTL: begin
            if (phase_end) begin
               state_d = dtcs_pkg::S_SETR; // Remote follows even if unused
            end
         end
         dtcs_pkg::S_SETR: begin
            if (phase_end) begin
               state_d = dtcs_pkg::S_INTR;
            end
         end
         dtcs_pkg::S_INTR: begin
            if (phase_end) begin
               state_d = dtcs_pkg::S_LATCH;
            end
         end
         dtcs_pkg::S_LATCH: begin
            state_d = dtcs_pkg::S_CMP; // Both results written together
         end
         dtcs_pkg::S_CMP: begin
            state_d = dtcs_pkg::S_IDLE;
         end
         default: begin
            state_d = dtcs_pkg::S_IDLE;
         end
      endcase
      if (abort) begin
         state_d = dtcs_pkg::S_IDLE; // Truncate, scratch is dropped
      end
   end

   // ****************************************
   // Sequencer registers
   // ****************************************
   // State and timer; timer restarts on every change of state
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= dtcs_pkg::S_IDLE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q) ? '0 :
                  (rate_done ? cnt_q : cnt_q + dtcs_pkg::CNT_W'(1));
      end
   end

   // Capture each 8-bit code at the end of its integration
   always_ff @(posedge clock) begin
      if (rst) begin
         scratch_local_q <= dtcs_pkg::TEMP_RST;
         scratch_remote_q <= dtcs_pkg::TEMP_RST;
      end else begin
         if (st_intl & phase_end) begin
            scratch_local_q <= adc_code;
         end
         if (st_intr & phase_end) begin
            scratch_remote_q <= adc_code;
         end
      end
   end

   // Visible results change only here, so older data stays readable
   always_ff @(posedge clock) begin
      if (rst) begin
         temp_local_q <= dtcs_pkg::TEMP_RST;
         temp_remote_q <= dtcs_pkg::TEMP_RST;
      end else if (st_latch) begin
         temp_local_q <= scratch_local_q;
         temp_remote_q <= scratch_remote_q;
      end
   end

   // Status and front-end controls; busy and front-end from the next state, done from the current state
   always_ff @(posedge clock) begin
      if (rst) begin
         busy_q <= 1'b0;
         integ_q <= 1'b0;
         chan_q <= 1'b0;
         done_q <= 1'b0;
         standby_q <= 1'b0;
         flags_q <= dtcs_pkg::FLAGS_RST;
         alert_oe_q <= 1'b0;
      end else begin
         // Busy drops once both results are latched, or on an abort with nothing latched
         busy_q <= (state_d != dtcs_pkg::S_IDLE) & (state_d != dtcs_pkg::S_CMP);
         integ_q <= (state_d == dtcs_pkg::S_INTL) | (state_d == dtcs_pkg::S_INTR);
         chan_q <= (state_d == dtcs_pkg::S_SETR) | (state_d == dtcs_pkg::S_INTR);
         done_q <= st_cmp;
         standby_q <= standby_now;
         flags_q <= flags_d;
         alert_oe_q <= |flags_d; // Pull the alert line low on any alarm
      end
   end

   // ****************************************
   // Serial pins
   // ****************************************
   // Clock edges found by sampling, never used as a clock
   always_ff @(posedge clock) begin
      if (rst) begin
         scl_prev_q <= 1'b1;
         sw_halt_prev_q <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
         sda_lvl_q <= 1'b1;
         sda_oe_q <= 1'b0;
      end else begin
         scl_prev_q <= scl_lvl;
         sw_halt_prev_q <= sw_halt;
         rise_q <= addr_valid_q & scl_lvl & ~scl_prev_q; // Quiet until filter primed
         fall_q <= addr_valid_q & ~scl_lvl & scl_prev_q; // No false edge after reset
         sda_lvl_q <= pins_if.clean[dtcs_pkg::PIN_SDA] | ~addr_valid_q; // Receive path
         sda_oe_q <= tx_pull_low; // Only ever pulls low or releases
      end
   end

   // Address straps caught once, after the sync pipe has filled
   always_ff @(posedge clock) begin
      if (rst) begin
         fill_q <= 3'h0;
         addr_q <= 2'h0;
         addr_valid_q <= 1'b0;
      end else if (!addr_valid_q) begin
         fill_q <= fill_q + 3'h1;
         if (fill_q == dtcs_pkg::ADDR_FILL) begin
            addr_q <= {pins_if.clean[dtcs_pkg::PIN_ADDR_HI],
                       pins_if.clean[dtcs_pkg::PIN_ADDR_LO]};
            addr_valid_q <= 1'b1;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign smb_data_out = 1'b0; // Open-drain: data level is always low
   assign alert_out = 1'b0;
   assign smb_data_oe = sda_oe_q;
   assign alert_oe = alert_oe_q;
   assign smb_clk_rise = rise_q;
   assign smb_clk_fall = fall_q;
   assign smb_data_level = sda_lvl_q;
   assign bus_addr_sel = addr_q;
   assign addr_valid = addr_valid_q;
   assign adc_integrate = integ_q;
   assign adc_channel_remote = chan_q;
   assign temp_local = temp_local_q;
   assign temp_remote = temp_remote_q;
   assign busy = busy_q;
   assign standby_active = standby_q;
   assign alarm_flags = flags_q;
   assign conv_done = done_q;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence conv_tail_s;
      st_latch ##1 st_cmp ##1 st_idle;
   endsequence
   sequence local_to_remote_s;
      (state_q == dtcs_pkg::S_SETR) ##1 (state_q == dtcs_pkg::S_SETR);
   endsequence

   standby_level_a: assert property (hw_hw_standby_pin |=> standby_active)
      else $error("standby pin low but not in standby");
   results_kept_a: assert property (hw_hw_standby_pin && !st_latch |=>
      $stable(temp_local) && $stable(temp_remote))
      else $error("results changed in hardware standby");
   addr_frozen_a: assert property (addr_valid |=> addr_valid && $stable(bus_addr_sel))
      else $error("latched address moved");
   alert_follow_a: assert property (alert_oe == (|alarm_flags))
      else $error("alert drive disagrees with alarms");
   sda_drive_a: assert property (tx_pull_low |=> smb_data_oe && !smb_data_out)
      else $error("data line not pulled low");
   capture_code_a: assert property (st_intl && phase_end && !abort |=>
      scratch_local_q == $past(adc_code))
      else $error("local code not captured");
   latch_copy_a: assert property (st_latch |=> temp_remote == $past(scratch_remote_q) &&
      temp_local == $past(scratch_local_q))
      else $error("results not copied from scratch");
   both_chan_a: assert property (st_intl && phase_end && !abort && SETTLE_CYC > 1 |=>
      local_to_remote_s)
      else $error("remote channel skipped");
   tail_order_a: assert property (st_intr && phase_end && !abort |=> conv_tail_s)
      else $error("latch and compare out of order");
   busy_span_a: assert property ((st_latch |-> busy) and (st_cmp |-> !busy))
      else $error("busy wrong around completion");
   hw_block_a: assert property (st_idle && hw_hw_standby_pin |=> st_idle)
      else $error("conversion started in hardware standby");
   abort_drop_a: assert property (abort |=> st_idle && !busy ##1 $stable(temp_local))
      else $error("aborted conversion left effects");

endmodule : dtcs_sequencer

// *** tb/dtcs_far_model.sv ***
// ****************************************
// Far side: front end and bus host
// ****************************************
module dtcs_far_model (
   // Clock
   input wire logic clock,
   // Front end
   input wire logic adc_integrate,
   input wire logic adc_channel_remote,
   input wire logic [7:0] code_l,
   input wire logic [7:0] code_r,
   output logic [7:0] adc_code,
   // Bus host
   input wire logic frame_en,
   input wire logic host_pull_low,
   input wire logic smb_data_oe,
   output logic smb_clk_pin,
   output logic smb_data_in,
   output int sent_rise
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] noise_q = 8'hA5; // Churns so a mistimed sample is caught

   // Code is only valid while integrating
   assign adc_code = adc_integrate ? (adc_channel_remote ? code_r : code_l) : noise_q;

   // Noise pattern outside integration
   always @(posedge clock) begin
      noise_q <= noise_q + 8'h5B;
   end

   // Wired-AND with pull-up: either party pulls low
   assign smb_data_in = !(host_pull_low || smb_data_oe);

   // Bus clock idles high; odd offset keeps it off the system edges
   initial begin
      smb_clk_pin = 1'b1;
      sent_rise = 0;
      #1.3;
      forever begin
         #62.5;
         // A started pulse is always finished
         if (frame_en || !smb_clk_pin) begin
            smb_clk_pin = ~smb_clk_pin;
            if (smb_clk_pin) begin
               sent_rise++;
            end
         end
      end
   end

endmodule : dtcs_far_model

// *** tb/dtcs_sequencer_tb_top.sv ***
module dtcs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Signals
   // ****************************************
   logic clock = 1'b0;
   logic rst, hw_standby_pin, addr_select_lo_pin, addr_select_hi_pin;
   logic smb_clk_pin, smb_data_in, smb_data_out, smb_data_oe, alert_out, alert_oe;
   logic tx_pull_low, smb_clk_rise, smb_clk_fall, smb_data_level, addr_valid;
   logic [1:0] bus_addr_sel;
   logic one_shot_cmd, sw_halt, alarm_clear, adc_integrate, adc_channel_remote;
   logic [7:0] lim_local_hi, lim_local_lo, lim_remote_hi, lim_remote_lo, adc_code;
   logic [7:0] temp_local, temp_remote, code_l, code_r;
   logic busy, standby_active, conv_done, frame_en, host_pull_low;
   logic [3:0] alarm_flags;
   int sent_rise, n_rise, n_fall, cyc;
   int n_mismatch = 0; // Failed comparisons
   int samples_checked = 0; // All comparisons

   // Short counts keep the run brief
   dtcs_sequencer #(.INTEG_CYC(20), .SETTLE_CYC(5), .RATE_CYC(30)) u_dtcs_sequencer (.*);
   dtcs_far_model u_dtcs_far_model (.*);

   // Clock and bus-edge pulse counters
   always #5 clock = ~clock;
   always @(posedge clock) begin
      n_rise <= n_rise + int'(smb_clk_rise);
      n_fall <= n_fall + int'(smb_clk_fall);
      cyc <= cyc + 1;
      // Hang guard, far above the expected length
      if (cyc == 4000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask : tick

   // ****************************************
   // Scenarios
   // ****************************************
   // One-shot conversion, timed and judged end to end
   task automatic conv(input logic [7:0] l, input logic [7:0] r, input logic [3:0] fl);
      int n, il, ir, bz;
      logic order_bad, held_bad;
      logic [7:0] pl, pr;
      n = 0;
      il = 0;
      ir = 0;
      bz = 0;
      order_bad = 1'b0;
      held_bad = 1'b0;
      pl = temp_local;
      pr = temp_remote;
      @(posedge clock);
      code_l <= l;
      code_r <= r;
      one_shot_cmd <= 1'b1;
      @(posedge clock);
      one_shot_cmd <= 1'b0;
      do begin
         @(posedge clock);
         #1;
         n++;
         // Local must finish before remote starts
         if (adc_integrate && adc_channel_remote) ir++;
         if (adc_integrate && !adc_channel_remote) il++;
         if (adc_integrate && !adc_channel_remote && ir > 0) order_bad = 1'b1;
         // Old results stay visible while busy
         if (busy && !conv_done) bz++;
         if (busy && !conv_done && (temp_local !== pl || temp_remote !== pr)) held_bad = 1;
      end while (!conv_done && n < 200);
      check("conv_cycles", n, 52);
      check("integ_local", il, 20);
      check("integ_remote", ir, 20);
      check("order", order_bad, 0);
      check("busy_seen", bz > 0, 1);
      check("held", held_bad, 0);
      check("busy_at_done", busy, 0);
      check("temp_local", temp_local, l);
      check("temp_remote", temp_remote, r);
      check("alarm_flags", alarm_flags, fl);
      check("alert_oe", alert_oe, |fl);
      check("alert_out", alert_out, 0);
      $display("done: conversion %0h %0h", l, r);
   endtask : conv

   // Clearing the sticky flags releases the alert
   task automatic clear_alarms();
      @(posedge clock);
      alarm_clear <= 1'b1;
      @(posedge clock);
      alarm_clear <= 1'b0;
      @(posedge clock);
      #1;
      check("flags_clr", alarm_flags, 0);
      check("alert_clr", alert_oe, 0);
      $display("done: clear alarms");
   endtask : clear_alarms

   // Standby arriving mid-conversion, by pin or by halt bit
   task automatic abort(input logic hw);
      logic done_seen, bz;
      logic [7:0] pl, pr;
      done_seen = 1'b0;
      bz = 1'b0;
      pl = temp_local;
      pr = temp_remote;
      @(posedge clock);
      code_l <= 8'h33;
      code_r <= 8'h34;
      one_shot_cmd <= 1'b1;
      if (!hw) sw_halt <= 1'b0;
      @(posedge clock);
      one_shot_cmd <= 1'b0;
      tick(15);
      if (hw) hw_standby_pin <= 1'b0;
      else sw_halt <= 1'b1;
      repeat (80) begin
         @(posedge clock);
         #1;
         if (conv_done) done_seen = 1'b1;
      end
      check("abort_done", done_seen, 0);
      check("abort_busy", busy, 0);
      check("keep_local", temp_local, pl);
      check("keep_remote", temp_remote, pr);
      check("standby", standby_active, 1);
      if (hw) begin
         // One-shot refused while the pin holds standby
         @(posedge clock);
         one_shot_cmd <= 1'b1;
         @(posedge clock);
         one_shot_cmd <= 1'b0;
         repeat (20) begin
            @(posedge clock);
            #1;
            bz = bz | busy;
         end
         check("hw_oneshot", bz, 0);
         @(posedge clock);
         hw_standby_pin <= 1'b1;
         tick(8);
      end
      $display("done: abort hw=%0d", hw);
   endtask : abort

   // Free-running mode starts conversions unprompted
   task automatic free_run();
      int n;
      n = 0;
      @(posedge clock);
      code_l <= 8'h21;
      code_r <= 8'h22;
      sw_halt <= 1'b0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (!conv_done && n < 150);
      check("free_done", conv_done, 1);
      check("free_local", temp_local, 8'h21);
      check("free_remote", temp_remote, 8'h22);
      @(posedge clock);
      sw_halt <= 1'b1;
      tick(4);
      $display("done: free run");
   endtask : free_run

   // Open-drain data line and sampled bus clock
   task automatic bus_pins();
      int r0, f0, s0;
      @(posedge clock);
      tx_pull_low <= 1'b1;
      @(posedge clock);
      #1;
      check("oe_on", smb_data_oe, 1);
      check("data_out", smb_data_out, 0);
      @(posedge clock);
      tx_pull_low <= 1'b0;
      host_pull_low <= 1'b1;
      tick(8);
      #1;
      check("oe_off", smb_data_oe, 0);
      check("rx_low", smb_data_level, 0);
      @(posedge clock);
      host_pull_low <= 1'b0;
      r0 = n_rise;
      f0 = n_fall;
      s0 = sent_rise;
      frame_en <= 1'b1;
      tick(100);
      frame_en <= 1'b0;
      tick(30);
      #1;
      check("rx_high", smb_data_level, 1);
      check("clk_rises", n_rise - r0, sent_rise - s0);
      check("clk_falls", n_fall - f0, sent_rise - s0);
      $display("done: bus pins");
   endtask : bus_pins

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rst = 1'b1;
      hw_standby_pin = 1'b1;
      addr_select_lo_pin = 1'b1;
      addr_select_hi_pin = 1'b0;
      {tx_pull_low, one_shot_cmd, alarm_clear, frame_en, host_pull_low} = 5'h00;
      sw_halt = 1'b1; // Software standby: one-shots still run
      lim_local_hi = 8'h40;
      lim_remote_hi = 8'h40;
      lim_local_lo = 8'h00;
      lim_remote_lo = 8'h00;
      code_l = 8'h00;
      code_r = 8'h00;
      n_rise = 0;
      n_fall = 0;
      cyc = 0;
      tick(4);
      #1;
      check("rst_temp", temp_local, dtcs_pkg::TEMP_RST);
      check("rst_flags", alarm_flags, dtcs_pkg::FLAGS_RST);
      check("rst_busy", busy, 0);
      @(posedge clock);
      rst <= 1'b0;
      tick(8);
      #1;
      check("addr", bus_addr_sel, 2'h1);
      check("addr_valid", addr_valid, 1);
      @(posedge clock);
      addr_select_lo_pin <= 1'b0;
      addr_select_hi_pin <= 1'b1;
      tick(10);
      #1;
      check("addr_kept", bus_addr_sel, 2'h1);
      $display("done: reset and straps");
      conv(8'h19, 8'h2A, 4'h0);
      conv(8'h50, 8'h7F, 4'hA);
      clear_alarms();
      conv(8'hF0, 8'h80, 4'h5);
      clear_alarms();
      free_run();
      abort(1'b1);
      abort(1'b0);
      bus_pins();
      tally_and_finish();
   end

endmodule : dtcs_sequencer_tb_top
